// ==== src/pitc_regs.svh ====
`ifndef PITC_REGS_SVH
`define PITC_REGS_SVH

// register map: one control register per port, fixed stride
`define PITC_NUM_PORTS 5
`define PITC_P1_OFS 8'h10
`define PITC_P2_OFS 8'h20
`define PITC_P3_OFS 8'h30
`define PITC_P4_OFS 8'h40
`define PITC_P5_OFS 8'h50
`define PITC_OFS_LOW_MASK 8'h0F

// control register fields
`define PITC_STORM_BIT 7
`define PITC_DSCP_BIT 6
`define PITC_PCP_BIT 5
`define PITC_PRIO_HI 4
`define PITC_PRIO_LO 3
`define PITC_INS_BIT 2
`define PITC_REM_BIT 1
`define PITC_CTRL_RESET 8'h00
`define PITC_CTRL_WMASK 8'hFE
`define PITC_UNMAPPED_RD 8'h00

`endif

// ==== src/pitc_pkg.sv ====
package pitc_pkg;

   // per-port control, bit for bit as the register
   typedef struct packed {
      logic storm_en;
      logic dscp_en;
      logic pcp_en;
      logic [1:0] port_prio;
      logic tag_ins;
      logic tag_rem;
      logic rsvd;
   } pitc_cfg_type;

   typedef pitc_cfg_type [4:0] pitc_cfg_arr_type;
   typedef logic [4:0][11:0] pitc_vid_arr_type;

   // ingress classification request
   typedef struct packed {
      logic [2:0] port;
      logic bcast;
      logic pcp_hit;
      logic [1:0] pcp_q;
      logic dscp_hit;
      logic [1:0] dscp_q;
   } pitc_in_pkt_type;

   typedef struct packed {
      logic storm_check;
      logic by_port;
      logic [1:0] queue;
   } pitc_in_res_type;

   // egress tag request
   typedef struct packed {
      logic [2:0] eg_port;
      logic [2:0] in_port;
      logic rx_tagged;
   } pitc_eg_pkt_type;

   typedef struct packed {
      logic ins;
      logic rem;
      logic [11:0] vid;
   } pitc_eg_res_type;

endpackage

// ==== src/pitc_prio_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pitc_regs.svh"

module pitc_prio_sel (
   // settings of the ingress port
   input wire pitc_pkg::pitc_cfg_type cfg_i,
   // packet seen by the classifiers
   input wire pitc_pkg::pitc_in_pkt_type pkt_i,
   // decision
   output pitc_pkg::pitc_in_res_type res_o
);
   import pitc_pkg::*;

   logic use_dscp;
   logic use_pcp;

   always_comb begin
      use_dscp = cfg_i.dscp_en & pkt_i.dscp_hit;
      use_pcp = cfg_i.pcp_en & pkt_i.pcp_hit;
      res_o.storm_check = cfg_i.storm_en & pkt_i.bcast;
      res_o.by_port = ~(use_dscp | use_pcp);
      if (use_dscp | use_pcp) begin
         // combined result of both classifiers wins over port priority
         res_o.queue = (use_dscp ? pkt_i.dscp_q : 2'h0)
                     | (use_pcp ? pkt_i.pcp_q : 2'h0);
      end else begin
         res_o.queue = cfg_i.port_prio;
      end
   end

endmodule
`default_nettype wire

// ==== src/pitc_port_ctrl.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pitc_regs.svh"

module pitc_port_ctrl (
   // clock, reset, enable
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   // register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   // settings seen by the switch core
   output pitc_pkg::pitc_cfg_arr_type PORT_CFG_O,
   // ingress classification
   input wire logic IN_REQ_I,
   input wire pitc_pkg::pitc_in_pkt_type IN_PKT_I,
   output logic IN_DONE_O,
   output pitc_pkg::pitc_in_res_type IN_RES_O,
   // egress tag handling
   input wire logic EG_REQ_I,
   input wire pitc_pkg::pitc_eg_pkt_type EG_PKT_I,
   input wire pitc_pkg::pitc_vid_arr_type PORT_VID_I,
   output logic EG_DONE_O,
   output pitc_pkg::pitc_eg_res_type EG_RES_O
);
   import pitc_pkg::*;

   // address to port index, hit flag in bit 3
   function automatic logic [3:0] addr_port(input logic [7:0] addr);
      logic [7:0] base;
      base = addr & ~`PITC_OFS_LOW_MASK;
      unique case (base)
         `PITC_P1_OFS: addr_port = 4'h8;
         `PITC_P2_OFS: addr_port = 4'h9;
         `PITC_P3_OFS: addr_port = 4'hA;
         `PITC_P4_OFS: addr_port = 4'hB;
         `PITC_P5_OFS: addr_port = 4'hC;
         default: addr_port = 4'h0;
      endcase
      if ((addr & `PITC_OFS_LOW_MASK) != 8'h00) begin
         addr_port = 4'h0;
      end
   endfunction

   // a port number names a real port
   function automatic logic port_ok(input logic [2:0] p);
      port_ok = (p < 3'(`PITC_NUM_PORTS));
   endfunction

   // reset release
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // register bank
   pitc_cfg_arr_type cfg_ff;
   logic [3:0] wr_dec;
   logic [3:0] rd_dec;
   logic [7:0] nxt_wval;

   always_comb begin
      wr_dec = addr_port(REG_ADDR_I);
      rd_dec = addr_port(REG_ADDR_I);
      nxt_wval = REG_WDATA_I & `PITC_CTRL_WMASK;
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= {`PITC_NUM_PORTS{`PITC_CTRL_RESET}};
      end else if (CE_I && REG_WR_I && wr_dec[3]) begin
         cfg_ff[wr_dec[2:0]] <= pitc_cfg_type'(nxt_wval);
      end
   end

   // read data, one cycle after the strobe
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_rdata = `PITC_UNMAPPED_RD;
      if (rd_dec[3]) begin
         nxt_rdata = 8'(cfg_ff[rd_dec[2:0]]);
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (CE_I) begin
         rdata_ff <= REG_RD_I ? nxt_rdata : 8'h00;
      end
   end
   assign REG_RDATA_O = rdata_ff;
   assign PORT_CFG_O = cfg_ff;

   // ingress classification
   pitc_cfg_type in_cfg;
   pitc_in_res_type in_res;
   pitc_in_res_type in_res_ff;
   logic in_done_ff;

   always_comb begin
      in_cfg = pitc_cfg_type'(`PITC_CTRL_RESET);
      if (port_ok(IN_PKT_I.port)) begin
         in_cfg = cfg_ff[IN_PKT_I.port];
      end
   end

   pitc_prio_sel u_prio_sel (
      .cfg_i(in_cfg),
      .pkt_i(IN_PKT_I),
      .res_o(in_res)
   );

   // settings sampled at the request edge
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         in_res_ff <= '0;
         in_done_ff <= 1'b0;
      end else if (CE_I) begin
         in_done_ff <= IN_REQ_I;
         if (IN_REQ_I) begin
            in_res_ff <= in_res;
         end
      end
   end
   assign IN_DONE_O = in_done_ff;
   assign IN_RES_O = in_res_ff;

   // egress tag decision
   pitc_cfg_type eg_cfg;
   pitc_eg_res_type eg_res;
   pitc_eg_res_type eg_res_ff;
   logic eg_done_ff;

   always_comb begin
      eg_cfg = pitc_cfg_type'(`PITC_CTRL_RESET);
      if (port_ok(EG_PKT_I.eg_port)) begin
         eg_cfg = cfg_ff[EG_PKT_I.eg_port];
      end
      eg_res.ins = eg_cfg.tag_ins & ~EG_PKT_I.rx_tagged;
      eg_res.rem = eg_cfg.tag_rem & EG_PKT_I.rx_tagged;
      eg_res.vid = 12'h000;
      if (eg_res.ins && port_ok(EG_PKT_I.in_port)) begin
         eg_res.vid = PORT_VID_I[EG_PKT_I.in_port];
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         eg_res_ff <= '0;
         eg_done_ff <= 1'b0;
      end else if (CE_I) begin
         eg_done_ff <= EG_REQ_I;
         if (EG_REQ_I) begin
            eg_res_ff <= eg_res;
         end
      end
   end
   assign EG_DONE_O = eg_done_ff;
   assign EG_RES_O = eg_res_ff;

   // checks
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!rst_n);

   sequence in_req_s;
      CE_I && IN_REQ_I && port_ok(IN_PKT_I.port);
   endsequence

   sequence eg_req_s;
      CE_I && EG_REQ_I && port_ok(EG_PKT_I.eg_port);
   endsequence

   sequence p1_wr_s;
      CE_I && REG_WR_I && !REG_RD_I && REG_ADDR_I == `PITC_P1_OFS;
   endsequence

   sequence p1_req_s;
      CE_I && IN_REQ_I && IN_PKT_I.port == 3'h0;
   endsequence

   sequence p3_rd_s;
      CE_I && REG_RD_I && REG_ADDR_I == `PITC_P3_OFS;
   endsequence

   reg_read_a: assert property (
      p3_rd_s |=> REG_RDATA_O == $past(8'(cfg_ff[2])) && IN_DONE_O == $past(IN_REQ_I))
      else $error("port 3 register read back wrong");

   storm_chk_a: assert property (
      in_req_s |=> IN_DONE_O && IN_RES_O.storm_check ==
         ($past(in_cfg.storm_en) && $past(IN_PKT_I.bcast)))
      else $error("storm check does not follow enable");

   dscp_only_a: assert property (
      in_req_s and (in_cfg.dscp_en && IN_PKT_I.dscp_hit && !in_cfg.pcp_en)
      |=> IN_RES_O.queue == $past(IN_PKT_I.dscp_q) && !IN_RES_O.by_port)
      else $error("dscp queue not used");

   pcp_only_a: assert property (
      in_req_s and (in_cfg.pcp_en && IN_PKT_I.pcp_hit && !in_cfg.dscp_en)
      |=> IN_RES_O.queue == $past(IN_PKT_I.pcp_q) && !IN_RES_O.by_port)
      else $error("802.1p queue not used");

   port_prio_a: assert property (
      in_req_s and !(in_cfg.dscp_en && IN_PKT_I.dscp_hit)
         and !(in_cfg.pcp_en && IN_PKT_I.pcp_hit)
      |=> IN_RES_O.queue == $past(in_cfg.port_prio) && IN_RES_O.by_port)
      else $error("port priority not used");

   or_prec_a: assert property (
      in_req_s and (in_cfg.dscp_en && IN_PKT_I.dscp_hit)
         and (in_cfg.pcp_en && IN_PKT_I.pcp_hit)
      |=> IN_RES_O.queue == ($past(IN_PKT_I.dscp_q) | $past(IN_PKT_I.pcp_q)))
      else $error("combined classifier result wrong");

   tag_ins_a: assert property (
      eg_req_s and (eg_cfg.tag_ins && !EG_PKT_I.rx_tagged)
      |=> EG_DONE_O && EG_RES_O.ins && !EG_RES_O.rem)
      else $error("tag not inserted");

   tagged_keep_a: assert property (
      eg_req_s and EG_PKT_I.rx_tagged |=> !EG_RES_O.ins)
      else $error("extra tag added to tagged packet");

   vid_source_a: assert property (
      eg_req_s and (eg_cfg.tag_ins && !EG_PKT_I.rx_tagged)
         and port_ok(EG_PKT_I.in_port)
      |=> EG_RES_O.vid == $past(PORT_VID_I[EG_PKT_I.in_port]))
      else $error("inserted vid not from ingress port");

   tag_rem_a: assert property (
      eg_req_s and EG_PKT_I.rx_tagged
      |=> EG_RES_O.rem == $past(eg_cfg.tag_rem))
      else $error("tag removal does not follow enable");

   untag_keep_a: assert property (
      eg_req_s and !EG_PKT_I.rx_tagged and !eg_cfg.tag_ins
      |=> !EG_RES_O.rem && !EG_RES_O.ins)
      else $error("untagged packet modified");

   wr_then_use_a: assert property (
      p1_wr_s ##1 p1_req_s
      |=> IN_RES_O.storm_check == ($past(REG_WDATA_I[7], 2) && $past(IN_PKT_I.bcast)))
      else $error("new setting not applied after write");

   sequence in_idle_s;
      CE_I && !IN_REQ_I;
   endsequence

   sequence eg_idle_s;
      CE_I && !EG_REQ_I;
   endsequence

   wr_store_a: assert property (
      p1_wr_s |=> 8'(PORT_CFG_O[0]) == ($past(REG_WDATA_I) & `PITC_CTRL_WMASK))
      else $error("port 1 write not stored");

   unmapped_wr_a: assert property (
      CE_I && REG_WR_I && REG_ADDR_I[3:0] != 4'h0 |=> $stable(PORT_CFG_O))
      else $error("write to unmapped address stored");

   unmapped_rd_a: assert property (
      CE_I && REG_RD_I && REG_ADDR_I[3:0] != 4'h0 |=> REG_RDATA_O == `PITC_UNMAPPED_RD)
      else $error("unmapped address read not zero");

   rd_once_a: assert property (
      CE_I && !REG_RD_I |=> REG_RDATA_O == 8'h00)
      else $error("read data held past one cycle");

   cfg_hold_a: assert property (
      CE_I && !REG_WR_I |=> $stable(PORT_CFG_O))
      else $error("register changed without a write");

   rsvd_zero_a: assert property (
      !PORT_CFG_O[0].rsvd && !PORT_CFG_O[1].rsvd && !PORT_CFG_O[2].rsvd
         && !PORT_CFG_O[3].rsvd && !PORT_CFG_O[4].rsvd)
      else $error("reserved bit stored");

   in_refused_a: assert property (
      CE_I && IN_REQ_I && !port_ok(IN_PKT_I.port)
      |=> IN_RES_O.by_port && IN_RES_O.queue == 2'h0 && !IN_RES_O.storm_check)
      else $error("unknown ingress port not given defaults");

   eg_refused_a: assert property (
      CE_I && EG_REQ_I && !port_ok(EG_PKT_I.eg_port)
      |=> !EG_RES_O.ins && !EG_RES_O.rem && EG_RES_O.vid == 12'h000)
      else $error("unknown egress port changed the packet");

   vid_zero_a: assert property (
      eg_req_s and !(eg_cfg.tag_ins && !EG_PKT_I.rx_tagged)
      |=> EG_RES_O.vid == 12'h000)
      else $error("vid given without tag insertion");

   in_pulse_a: assert property (
      in_idle_s |=> !IN_DONE_O)
      else $error("ingress done held too long");

   eg_pulse_a: assert property (
      eg_idle_s |=> !EG_DONE_O)
      else $error("egress done held too long");

   in_hold_a: assert property (
      in_idle_s |=> $stable(IN_RES_O))
      else $error("ingress result moved without a request");

   eg_hold_a: assert property (
      eg_idle_s |=> $stable(EG_RES_O))
      else $error("egress result moved without a request");

   ce_freeze_a: assert property (
      !CE_I |=> $stable(cfg_ff) && $stable(IN_DONE_O) && $stable(EG_RES_O))
      else $error("state moved with clock enable low");

endmodule
`default_nettype wire

// ==== testbench/pitc_port_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import pitc_pkg::*;

   typedef struct packed {
      logic [7:0] cfg;
      pitc_in_pkt_type pkt;
      pitc_in_res_type res;
   } pitc_tb_in_row_type;

   typedef struct packed {
      logic [7:0] cfg;
      pitc_eg_pkt_type pkt;
      pitc_eg_res_type res;
   } pitc_tb_eg_row_type;

   logic clock;
   logic rst_n;
   logic ce;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   pitc_cfg_arr_type port_cfg;
   logic in_req;
   pitc_in_pkt_type in_pkt;
   logic in_done;
   pitc_in_res_type in_res;
   logic eg_req;
   pitc_eg_pkt_type eg_pkt;
   pitc_vid_arr_type port_vid;
   logic eg_done;
   pitc_eg_res_type eg_res;
   int num_errors;
   int checks;

   // ingress cases: settings, packet, expected result
   pitc_tb_in_row_type in_rows [7] = '{
      {8'h19, 10'h040, 4'h7}, {8'h80, 10'h0C6, 4'hC}, {8'h48, 10'h106, 4'h2},
      {8'h30, 10'h1AE, 4'h1}, {8'hF8, 10'h22E, 4'h3}, {8'h60, 10'h218, 4'h4},
      {8'hFF, 10'h2FF, 4'h4}};
   // egress cases: settings of the output port, packet, expected result
   pitc_tb_eg_row_type eg_rows [8] = '{
      {8'h04, 7'h04, 14'h2303}, {8'h04, 7'h05, 14'h0000}, {8'h02, 7'h17, 14'h1000},
      {8'h02, 7'h16, 14'h0000}, {8'h06, 7'h28, 14'h2505}, {8'h06, 7'h21, 14'h1000},
      {8'h04, 7'h4A, 14'h2000}, {8'h04, 7'h40, 14'h2101}};

   pitc_port_ctrl i_pitc_port_ctrl (
      .CLOCK_I(clock), .RST_N_I(rst_n), .CE_I(ce),
      .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
      .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .PORT_CFG_O(port_cfg),
      .IN_REQ_I(in_req), .IN_PKT_I(in_pkt), .IN_DONE_O(in_done), .IN_RES_O(in_res),
      .EG_REQ_I(eg_req), .EG_PKT_I(eg_pkt), .PORT_VID_I(port_vid),
      .EG_DONE_O(eg_done), .EG_RES_O(eg_res)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", 16'(reg_rdata), 16'(e));
   endtask

   task automatic do_in(input pitc_in_pkt_type p, input pitc_in_res_type e);
      @(posedge clock);
      in_req <= 1'b1;
      in_pkt <= p;
      @(posedge clock);
      in_req <= 1'b0;
      #1;
      chk("in_done", 16'(in_done), 16'h0001);
      chk("in_res", 16'(in_res), 16'(e));
   endtask

   task automatic do_eg(input pitc_eg_pkt_type p, input pitc_eg_res_type e);
      @(posedge clock);
      eg_req <= 1'b1;
      eg_pkt <= p;
      @(posedge clock);
      eg_req <= 1'b0;
      #1;
      chk("eg_done", 16'(eg_done), 16'h0001);
      chk("eg_res", 16'(eg_res), 16'(e));
   endtask

   initial begin
      #200000;
      num_errors++;
      complete_run();
   end

   initial begin
      logic [7:0] a;
      rst_n = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      in_req = 1'b0;
      in_pkt = '0;
      eg_req = 1'b0;
      eg_pkt = '0;
      port_vid = {12'h505, 12'h404, 12'h303, 12'h202, 12'h101};
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("port_cfg", 16'(port_cfg[4:3]), 16'h0000);
      for (int i = 0; i < 7; i++) begin
         a = {1'b0, in_rows[i].pkt.port + 3'd1, 4'h0};
         wr(a, in_rows[i].cfg);
         rd(a, (in_rows[i].pkt.port < 3'd5) ? (in_rows[i].cfg & 8'hFE) : 8'h00);
         do_in(in_rows[i].pkt, in_rows[i].res);
      end
      $display("test ingress rows done");
      // write and request on one edge: the request still sees the old queue
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= 8'h10;
      reg_wdata <= 8'h08;
      in_req <= 1'b1;
      in_pkt <= '0;
      @(posedge clock);
      reg_wr <= 1'b0;
      in_req <= 1'b0;
      #1;
      chk("in_res_old", 16'(in_res), 16'h0007);
      do_in('0, 4'h5);
      chk("port_cfg0", 16'(port_cfg[0]), 16'h0008);
      $display("test same edge done");
      wr(8'h18, 8'hFF);
      rd(8'h18, 8'h00);
      rd(8'h10, 8'h08);
      $display("test unmapped done");
      // write, then a request on the very next edge sees the new setting
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= 8'h10;
      reg_wdata <= 8'h88;
      @(posedge clock);
      reg_wr <= 1'b0;
      in_req <= 1'b1;
      in_pkt <= 10'h040;
      @(posedge clock);
      in_req <= 1'b0;
      #1;
      chk("in_res_new", 16'(in_res), 16'h000D);
      $display("test write then use done");
      do_eg(7'h50, 14'h0000);
      for (int i = 0; i < 8; i++) begin
         a = {1'b0, eg_rows[i].pkt.eg_port + 3'd1, 4'h0};
         wr(a, eg_rows[i].cfg);
         do_eg(eg_rows[i].pkt, eg_rows[i].res);
      end
      $display("test egress rows done");
      // clock enable low: strobe and request at that edge are ignored
      @(posedge clock);
      ce <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= 8'h10;
      reg_wdata <= 8'hFF;
      in_req <= 1'b1;
      @(posedge clock);
      ce <= 1'b1;
      reg_wr <= 1'b0;
      in_req <= 1'b0;
      #1;
      chk("port_cfg0_ce", 16'(port_cfg[0]), 16'h0004);
      chk("in_done_ce", 16'(in_done), 16'h0000);
      $display("test clock enable done");
      wr(8'h50, 8'hFE);
      #1;
      chk("port_cfg4", 16'(port_cfg[4]), 16'h00FE);
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      #1;
      chk("port_cfg4_rst", 16'(port_cfg[4]), 16'h0000);
      chk("in_res_rst", 16'(in_res), 16'h0000);
      chk("eg_res_rst", 16'(eg_res), 16'h0000);
      @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      for (int i = 1; i < 6; i++) begin
         rd(8'(i * 16), 8'h00);
      end
      $display("test reset done");
      complete_run();
   end
endmodule

`default_nettype wire
